// ---- ebc_host.sv ----
// Processor-side end: AXI4-Lite registers drive accesses on the I/O port.
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
module ebc_host
	import ebc_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Interrupt
	output logic             irq,
	// Device I/O port
	ebc_io_if.core           io
);

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ISSUE = 2'b01,
		ST_WAIT  = 2'b10
	} ebc_host_fsm_type;

	typedef struct packed {
		ebc_host_fsm_type fsm;
		logic             aw_ok;
		logic [4:0]       aw_addr;
		logic             w_ok;
		logic [31:0]      w_data;
		logic             w_strb0;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
		logic [1:0]       io_addr;
		logic             io_wr;
		logic             io_rd;
		logic [7:0]       io_wdata;
		logic             is_read;
		logic [7:0]       result;
		logic [1:0]       stat;
		logic [1:0]       mask;
		logic             gie;
		logic             irq_prev;
		logic             irq;
	} ebc_host_state_type;

	ebc_host_state_type r_reg;
	ebc_host_state_type r_next;
	logic [1:0]         events;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		r_next = r_reg;
		events = 2'h0;
		r_next.io_wr = 1'b0;
		r_next.io_rd = 1'b0;
		r_next.irq_prev = io.irq;
		events[EV_READY] = io.irq & ~r_reg.irq_prev;

		if (s_axi_awvalid && !r_reg.aw_ok && !r_reg.bvalid) begin
			r_next.aw_ok   = 1'b1;
			r_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !r_reg.w_ok && !r_reg.bvalid) begin
			r_next.w_ok    = 1'b1;
			r_next.w_data  = s_axi_wdata;
			r_next.w_strb0 = s_axi_wstrb[0];
		end
		if (r_reg.bvalid && s_axi_bready) begin
			r_next.bvalid = 1'b0;
		end

		// Access sequencer: one pulse, then wait out the stall.
		case (r_reg.fsm)
			ST_ISSUE: begin
				r_next.fsm = ST_WAIT;
			end
			ST_WAIT: begin
				if (!io.stall) begin
					if (r_reg.is_read) begin
						r_next.result = io.io_rdata;
					end
					events[EV_DONE] = 1'b1;
					r_next.fsm = ST_IDLE;
				end
			end
			default: begin
				r_next.fsm = ST_IDLE;
			end
		endcase

		// Both halves present: perform the write and answer.
		if (r_reg.aw_ok && r_reg.w_ok) begin
			r_next.aw_ok  = 1'b0;
			r_next.w_ok   = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp  = RESP_OKAY;
			case (r_reg.aw_addr)
				AXI_COMMAND: begin
					if (r_reg.w_strb0 && r_reg.fsm == ST_IDLE) begin
						r_next.fsm      = ST_ISSUE;
						r_next.io_addr  = r_reg.w_data[CMD_IO_ADDR_LSB +: 2];
						r_next.is_read  = r_reg.w_data[CMD_READ_BIT];
						r_next.io_rd    = r_reg.w_data[CMD_READ_BIT];
						r_next.io_wr    = ~r_reg.w_data[CMD_READ_BIT];
						r_next.io_wdata = r_reg.w_data[7:0];
					end
				end
				AXI_IRQ_MASK: begin
					if (r_reg.w_strb0) r_next.mask = r_reg.w_data[1:0];
				end
				AXI_CONTROL: begin
					if (r_reg.w_strb0) r_next.gie = r_reg.w_data[0];
				end
				AXI_RESULT, AXI_IRQ_STAT: begin
					r_next.bresp = RESP_OKAY;
				end
				default: begin
					r_next.bresp = RESP_SLVERR;
				end
			endcase
		end

		if (r_reg.rvalid && s_axi_rready) begin
			r_next.rvalid = 1'b0;
		end
		r_next.stat = r_reg.stat | events;
		if (s_axi_arvalid && !r_reg.rvalid) begin
			r_next.rvalid = 1'b1;
			r_next.rresp  = RESP_OKAY;
			r_next.rdata  = 32'h0000_0000;
			case (s_axi_araddr)
				AXI_COMMAND: r_next.rdata = 32'h0000_0000;
				AXI_RESULT: begin
					r_next.rdata[7:0]          = r_reg.result;
					r_next.rdata[RES_BUSY_BIT] = (r_reg.fsm != ST_IDLE);
				end
				AXI_IRQ_STAT: begin
					r_next.rdata[1:0] = r_reg.stat;
					// Clearing on read; a same-cycle event still lands.
					r_next.stat = events;
				end
				AXI_IRQ_MASK: r_next.rdata[1:0] = r_reg.mask;
				AXI_CONTROL:  r_next.rdata[0]   = r_reg.gie;
				default:      r_next.rresp      = RESP_SLVERR;
			endcase
		end

		r_next.irq = |(r_next.stat & r_next.mask);

		if (!aresetn) begin
			r_next = '0;
			r_next.fsm = ST_IDLE;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		r_reg <= r_next;
	end

	assign s_axi_awready    = ~r_reg.aw_ok & ~r_reg.bvalid;
	assign s_axi_wready     = ~r_reg.w_ok & ~r_reg.bvalid;
	assign s_axi_bvalid     = r_reg.bvalid;
	assign s_axi_bresp      = r_reg.bresp;
	assign s_axi_arready    = ~r_reg.rvalid;
	assign s_axi_rvalid     = r_reg.rvalid;
	assign s_axi_rdata      = r_reg.rdata;
	assign s_axi_rresp      = r_reg.rresp;
	assign irq              = r_reg.irq;
	assign io.io_addr       = r_reg.io_addr;
	assign io.io_wr         = r_reg.io_wr;
	assign io.io_rd         = r_reg.io_rd;
	assign io.io_wdata      = r_reg.io_wdata;
	assign io.global_irq_en = r_reg.gie;

endmodule : ebc_host

// ---- ebc_pkg.sv ----
// Shared constants of the EEPROM byte access controller.
package ebc_pkg;

	// ------------------------------------------------------------
	// Device register map in the processor I/O space
	// ------------------------------------------------------------
	localparam logic [1:0] IO_ADDRESS = 2'h0;
	localparam logic [1:0] IO_DATA    = 2'h1;
	localparam logic [1:0] IO_CONTROL = 2'h2;

	// Control register fields.
	localparam int CTL_READ_STROBE  = 0;
	localparam int CTL_WRITE_STROBE = 1;
	localparam int CTL_MASTER_WE    = 2;
	localparam int CTL_READY_IRQ_EN = 3;
	localparam int CTL_MODE_LSB     = 4;

	// ------------------------------------------------------------
	// Storage and programming modes
	// ------------------------------------------------------------
	localparam int NV_BYTES  = 64;
	localparam int NV_ADDR_W = 6;
	localparam logic [1:0] MODE_ERASE_WRITE = 2'h0;
	localparam logic [1:0] MODE_ERASE_ONLY  = 2'h1;
	localparam logic [1:0] MODE_WRITE_ONLY  = 2'h2;
	localparam logic [1:0] MODE_RESERVED    = 2'h3;
	localparam logic [7:0] ERASED_BYTE      = 8'hFF;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam logic [2:0] READ_STALL_CYCLES  = 3'h4;
	localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2;
	localparam logic [2:0] MASTER_WE_CYCLES   = 3'h4;
	localparam int ERASE_WRITE_TIME_US = 3400;
	localparam int SPLIT_TIME_US       = 1800;
	localparam int OSC_FREQ_KHZ        = 8000;
	localparam int TICK_W              = 16;
	localparam int ERASE_WRITE_TICKS   = ERASE_WRITE_TIME_US * OSC_FREQ_KHZ / 1000;
	localparam int SPLIT_TICKS         = SPLIT_TIME_US * OSC_FREQ_KHZ / 1000;

	// ------------------------------------------------------------
	// Controller registers on AXI4-Lite (byte addresses)
	// ------------------------------------------------------------
	localparam logic [4:0] AXI_COMMAND   = 5'h00;
	localparam logic [4:0] AXI_RESULT    = 5'h04;
	localparam logic [4:0] AXI_IRQ_STAT  = 5'h08;
	localparam logic [4:0] AXI_IRQ_MASK  = 5'h0C;
	localparam logic [4:0] AXI_CONTROL   = 5'h10;
	localparam int CMD_IO_ADDR_LSB = 8;
	localparam int CMD_READ_BIT    = 10;
	localparam int RES_BUSY_BIT    = 8;
	localparam int EV_DONE         = 0;
	localparam int EV_READY        = 1;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ebc_pkg

// ---- ebc_io_if.sv ----
// Processor I/O port between the controller core end and the EEPROM device end.
interface ebc_io_if;
	logic [1:0] io_addr;
	logic       io_wr;
	logic       io_rd;
	logic [7:0] io_wdata;
	logic [7:0] io_rdata;
	logic       stall;
	logic       irq;
	logic       global_irq_en;

	modport dev (
		input  io_addr, io_wr, io_rd, io_wdata, global_irq_en,
		output io_rdata, stall, irq
	);
	modport core (
		output io_addr, io_wr, io_rd, io_wdata, global_irq_en,
		input  io_rdata, stall, irq
	);
endinterface : ebc_io_if

// ---- ebc_device.sv ----
// EEPROM data memory with its address, data and control registers.
//
// Function
// - 64 bytes, each byte individually addressable.
// - Read stalls processor four clock cycles.
// - Write start stalls processor two cycles.
// - Mode zero: erase and write together.
// - Write strobe holds until programming completes.
// - No other operation while programming.
// - Mode one: erase addressed byte only.
// - Mode two: write without erasing first.
// - Software erases before write-only mode.
// - Self-timed; software polls busy flag.
// - Programming timed by calibrated oscillator.
// - Read strobe loads byte into data.
// - Registers reachable in I/O space.
// - Times 3.4ms and 1.8ms; mode three reserved.
// - Master enable self-clears after four cycles.
// - Mode locked while busy; reset clears it only when idle.
// - Ready interrupt while strobe clear, enabled.
module ebc_device
	import ebc_pkg::*;
#(
	parameter int ERASE_WRITE_COUNT = ERASE_WRITE_TICKS,
	parameter int SPLIT_COUNT       = SPLIT_TICKS
) (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Calibrated oscillator tick pin
	input  wire logic osc_tick,
	// Processor I/O port
	ebc_io_if.dev     io
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [NV_BYTES-1:0][7:0] mem;
		logic [NV_ADDR_W-1:0]     addr;
		logic [7:0]               data;
		logic [1:0]               mode;
		logic                     ready_irq_en;
		logic                     write_strobe;
		logic [2:0]               mwe_cnt;
		logic [2:0]               stall_cnt;
		logic [NV_ADDR_W-1:0]     op_addr;
		logic [7:0]               op_data;
		logic [1:0]               op_mode;
		logic [TICK_W-1:0]        ticks;
		logic [2:0]               sync;
		logic [7:0]               rdata;
		logic                     stall;
		logic                     irq;
	} ebc_dev_state_type;

	ebc_dev_state_type r_reg;
	ebc_dev_state_type r_next;

	localparam logic [TICK_W-1:0] EW_LIMIT = TICK_W'(ERASE_WRITE_COUNT);
	localparam logic [TICK_W-1:0] SP_LIMIT = TICK_W'(SPLIT_COUNT);

	logic                    tick_edge;
	logic [TICK_W-1:0]       op_limit;
	logic                    master_we;
	logic [7:0]              control_view;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Only the second and third stages are looked at; the first one settles.
	assign tick_edge = r_reg.sync[1] & ~r_reg.sync[2];
	assign op_limit  = (r_reg.op_mode == MODE_ERASE_WRITE) ? EW_LIMIT : SP_LIMIT;
	assign master_we = (r_reg.mwe_cnt != 3'h0);
	assign control_view = {2'h0, r_reg.mode, r_reg.ready_irq_en, master_we,
		r_reg.write_strobe, 1'b0};

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.sync = {r_reg.sync[1:0], osc_tick};
		if (r_reg.mwe_cnt != 3'h0) begin
			r_next.mwe_cnt = r_reg.mwe_cnt - 3'h1;
		end
		if (r_reg.stall_cnt != 3'h0) begin
			r_next.stall_cnt = r_reg.stall_cnt - 3'h1;
		end

		if (r_reg.write_strobe && tick_edge) begin
			r_next.ticks = r_reg.ticks + TICK_W'(1);
			if (r_reg.ticks + TICK_W'(1) >= op_limit) begin
				r_next.write_strobe = 1'b0;
				r_next.ticks        = '0;
				case (r_reg.op_mode)
					MODE_ERASE_WRITE: begin
						r_next.mem[r_reg.op_addr] = r_reg.op_data;
					end
					MODE_ERASE_ONLY: begin
						r_next.mem[r_reg.op_addr] = ERASED_BYTE;
					end
					MODE_WRITE_ONLY: begin
						r_next.mem[r_reg.op_addr] = r_reg.mem[r_reg.op_addr] & r_reg.op_data;
					end
					default: begin
						r_next.mem = r_reg.mem;
					end
				endcase
			end
		end

		if (io.io_wr) begin
			case (io.io_addr)
				IO_ADDRESS: begin
					r_next.addr = io.io_wdata[NV_ADDR_W-1:0];
				end
				IO_DATA: begin
					r_next.data = io.io_wdata;
				end
				IO_CONTROL: begin
					r_next.ready_irq_en = io.io_wdata[CTL_READY_IRQ_EN];
					if (!r_reg.write_strobe) begin
						r_next.mode = io.io_wdata[CTL_MODE_LSB +: 2];
					end
					if (io.io_wdata[CTL_MASTER_WE]) begin
						r_next.mwe_cnt = MASTER_WE_CYCLES;
					end else begin
						r_next.mwe_cnt = 3'h0;
					end
					if (!r_reg.write_strobe) begin
						// strobe needs master enable
						// The mode written together with the strobe is the one that runs.
						if (io.io_wdata[CTL_WRITE_STROBE] && master_we
							&& io.io_wdata[CTL_MODE_LSB +: 2] != MODE_RESERVED) begin
							r_next.write_strobe = 1'b1;
							r_next.op_addr      = r_reg.addr;
							r_next.op_data      = r_reg.data;
							r_next.op_mode      = io.io_wdata[CTL_MODE_LSB +: 2];
							r_next.ticks        = '0;
							r_next.mwe_cnt      = 3'h0;
							r_next.stall_cnt    = WRITE_STALL_CYCLES;
						end else if (io.io_wdata[CTL_READ_STROBE]) begin
							r_next.data      = r_reg.mem[r_reg.addr];
							r_next.stall_cnt = READ_STALL_CYCLES;
						end
					end
				end
				default: begin
					r_next.addr = r_reg.addr;
				end
			endcase
		end

		if (io.io_rd) begin
			case (io.io_addr)
				IO_ADDRESS: r_next.rdata = {2'h0, r_reg.addr};
				IO_DATA:    r_next.rdata = r_reg.data;
				IO_CONTROL: r_next.rdata = control_view;
				default:    r_next.rdata = 8'h00;
			endcase
		end

		r_next.stall = (r_next.stall_cnt != 3'h0);
		r_next.irq = r_next.ready_irq_en & io.global_irq_en & ~r_next.write_strobe;

		// reset keeps a running operation alive
		if (!aresetn) begin
			r_next.addr         = '0;
			r_next.data         = 8'h00;
			r_next.ready_irq_en = 1'b0;
			r_next.mwe_cnt      = 3'h0;
			r_next.stall_cnt    = 3'h0;
			r_next.rdata        = 8'h00;
			r_next.stall        = 1'b0;
			r_next.irq          = 1'b0;
			r_next.sync         = 3'h0;
			// A strobe of unknown value takes the idle branch, so the first reset clears it.
			if (r_reg.write_strobe) begin
				r_next.mode = r_reg.mode;
			end else begin
				r_next.mode         = MODE_ERASE_WRITE;
				r_next.write_strobe = 1'b0;
				r_next.ticks        = '0;
				r_next.op_addr      = '0;
				r_next.op_data      = 8'h00;
				r_next.op_mode      = MODE_ERASE_WRITE;
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// byte array held in the state
	always_ff @(posedge aclk) begin
		r_reg <= r_next;
	end

	assign io.io_rdata = r_reg.rdata;
	assign io.stall    = r_reg.stall;
	assign io.irq      = r_reg.irq;

endmodule : ebc_device

// ---- ebc_asserts.sv ----
// Concurrent checks on the I/O port between the controller host end and the device end.
module ebc_asserts
	import ebc_pkg::*;
(
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Processor I/O port
	input wire logic [1:0] io_addr,
	input wire logic       io_wr,
	input wire logic       io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic       stall,
	input wire logic       irq,
	input wire logic       global_irq_en
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ----------
	// Helper logic
	// ----------
	logic       ctl_wr;
	logic [2:0] me_age_reg;

	assign ctl_wr = io_wr && (io_addr == IO_CONTROL);

	// Cycles since the master enable was last set; seven means it is not armed.
	always_ff @(posedge aclk) begin
		if (!aresetn || (ctl_wr && !io_wdata[2]))
			me_age_reg <= 3'h7;
		else if (ctl_wr)
			me_age_reg <= 3'h1;
		else if (me_age_reg != 3'h7)
			me_age_reg <= me_age_reg + 3'h1;
	end

	// ----------
	// Properties
	// ----------
	a_read_stall: assert property ($rose(stall) && $past(ctl_wr && io_wdata[1:0] == 2'b01)
		|-> stall[*4] ##1 !stall) else $error("read stall length wrong");
	a_write_stall: assert property ($rose(stall) && $past(ctl_wr && io_wdata[1:0] == 2'b10)
		|-> stall[*2] ##1 !stall) else $error("write stall length wrong");
	a_stall_cause: assert property ($rose(stall) |-> $past(ctl_wr && |io_wdata[1:0]))
		else $error("stall without a strobe write");
	a_master_window: assert property (ctl_wr && io_wdata[1:0] == 2'b10 && me_age_reg > 3'h4
		|=> !stall) else $error("write started without armed master enable");
	a_mode_reserved: assert property (ctl_wr && io_wdata[5:4] == MODE_RESERVED
		&& io_wdata[1:0] == 2'b10 |=> !stall) else $error("reserved mode started programming");
	a_irq_global: assert property (!global_irq_en && $past(!global_irq_en) |-> !irq)
		else $error("interrupt while globally disabled");
	a_irq_busy_low: assert property ($rose(stall) && $past(ctl_wr && io_wdata[1:0] == 2'b10)
		|=> !irq[*2]) else $error("interrupt during programming");
	a_rdata_hold: assert property (!$past(io_rd) |-> $stable(io_rdata))
		else $error("read data changed without a read");
endmodule : ebc_asserts

// ---- eeprom_byte_access_controller_tb.sv ----
// Self-checking bench: host and device joined by the I/O port, driven over AXI4-Lite.
module eeprom_byte_access_controller_tb
	import ebc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// Short programming counts keep the run brief; the oscillator ticks every four cycles.
	localparam int EW_N = 20;
	localparam int SP_N = 10;

	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        osc_tick = 1'b0;
	logic [4:0]  s_axi_awaddr = 5'h00;
	logic        s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b1;
	logic [4:0]  s_axi_araddr = 5'h00;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b1;
	logic        s_axi_awready;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        host_irq;
	int          n_errors = 0;
	int          n_tests = 0;
	int          cyc = 0;
	int          t0 = 0;
	int          run = 0;
	int          last_stall = 0;
	int          n_stall = 0;
	logic [3:0]  osc_div = 4'h0;
	logic [7:0]  ta[4] = '{8'h05, 8'h05, 8'h00, 8'h3F};
	logic [7:0]  td[4] = '{8'h00, 8'h3C, 8'h11, 8'h5A};
	logic [1:0]  tm[4] = '{MODE_ERASE_ONLY, MODE_WRITE_ONLY, MODE_ERASE_WRITE, MODE_ERASE_WRITE};
	logic [7:0]  te[4] = '{ERASED_BYTE, 8'h3C, 8'h11, 8'h5A};

	ebc_io_if ebc_io_if_inst ();
	ebc_host ebc_host_inst (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.irq(host_irq), .io(ebc_io_if_inst)
	);
	ebc_device #(.ERASE_WRITE_COUNT(EW_N), .SPLIT_COUNT(SP_N)) ebc_device_inst (
		.aclk(aclk), .aresetn(aresetn), .osc_tick(osc_tick), .io(ebc_io_if_inst)
	);
	ebc_asserts ebc_asserts_inst (
		.aclk(aclk), .aresetn(aresetn), .io_addr(ebc_io_if_inst.io_addr),
		.io_wr(ebc_io_if_inst.io_wr), .io_rd(ebc_io_if_inst.io_rd),
		.io_wdata(ebc_io_if_inst.io_wdata), .io_rdata(ebc_io_if_inst.io_rdata),
		.stall(ebc_io_if_inst.stall), .irq(ebc_io_if_inst.irq),
		.global_irq_en(ebc_io_if_inst.global_irq_en)
	);

	initial forever #2.5 aclk = ~aclk;

	// Oscillator pin, cycle count and stall episode monitor.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		osc_div <= osc_div + 4'h1;
		osc_tick <= osc_div[1];
		if (ebc_io_if_inst.stall === 1'b1)
			run <= run + 1;
		else if (run != 0) begin
			last_stall <= run;
			n_stall <= n_stall + 1;
			run <= 0;
		end
	end

	// ----------
	// Tasks
	// ----------
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tmo(input int i);
		if (i >= 200) begin
			n_errors++;
			$display("mismatch at %0t: wait timed out", $time);
			final_report();
		end
	endtask : tmo

	task automatic tend(input string s);
		$display("test %s done", s);
	endtask : tend

	task automatic axi_write(input logic [4:0] a, input logic [31:0] d, output logic [1:0] rsp);
		int i;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(posedge aclk);
			if (s_axi_bvalid === 1'b1)
				break;
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		rsp = s_axi_bresp;
		tmo(i);
	endtask : axi_write

	task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] rsp);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(posedge aclk);
			if (s_axi_rvalid === 1'b1)
				break;
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		d = s_axi_rdata;
		rsp = s_axi_rresp;
		tmo(i);
	endtask : axi_read

	task automatic cmd(input logic [1:0] a, input logic [7:0] d, input logic rd);
		logic [1:0] rsp;
		axi_write(AXI_COMMAND, {21'h0, rd, a, d}, rsp);
	endtask : cmd

	task automatic wait_host;
		logic [31:0] r;
		logic [1:0]  rsp;
		int          i;
		for (i = 0; i < 200; i++) begin
			axi_read(AXI_RESULT, r, rsp);
			if (r[RES_BUSY_BIT] === 1'b0)
				break;
		end
		tmo(i);
	endtask : wait_host

	task automatic dev_wr(input logic [1:0] a, input logic [7:0] d);
		cmd(a, d, 1'b0);
		wait_host();
	endtask : dev_wr

	task automatic dev_rd(input logic [1:0] a, output logic [7:0] b);
		logic [31:0] r;
		logic [1:0]  rsp;
		cmd(a, 8'h00, 1'b1);
		wait_host();
		axi_read(AXI_RESULT, r, rsp);
		b = r[7:0];
	endtask : dev_rd

	task automatic prog_start(input logic [7:0] a, d, input logic [1:0] m, input logic [7:0] ie);
		int k;
		k = n_stall;
		dev_wr(IO_ADDRESS, a);
		dev_wr(IO_DATA, d);
		cmd(IO_CONTROL, {2'b00, m, 4'h4} | ie, 1'b0);
		cmd(IO_CONTROL, {2'b00, m, 4'h6} | ie, 1'b0);
		t0 = cyc;
		wait_host();
		check(32'(n_stall - k), 32'h1);
		check(32'(last_stall), 32'h2);
	endtask : prog_start

	task automatic prog_end(input logic [1:0] m);
		logic [7:0] b;
		int         i;
		int         n;
		n = (m == MODE_ERASE_WRITE) ? EW_N * 4 : SP_N * 4;
		for (i = 0; i < 200; i++) begin
			dev_rd(IO_CONTROL, b);
			if (b[1] === 1'b0)
				break;
		end
		tmo(i);
		check(32'(cyc - t0 >= n - 8 && cyc - t0 <= n + 30), 32'h1);
	endtask : prog_end

	task automatic mem_rd(input logic [7:0] a, output logic [7:0] b);
		dev_wr(IO_ADDRESS, a);
		dev_wr(IO_CONTROL, 8'h01);
		check(32'(last_stall), 32'h4);
		dev_rd(IO_DATA, b);
	endtask : mem_rd

	// ----------
	// Main sequence
	// ----------
	initial begin
		logic [31:0] r;
		logic [1:0]  rsp;
		logic [7:0]  b;
		int          i;
		int          k;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 3; i++) begin
			dev_rd(i[1:0], b);
			check(32'(b), 32'h0);
		end
		axi_read(5'h14, r, rsp);
		check(32'(rsp), 32'(RESP_SLVERR));
		axi_write(5'h14, 32'h0, rsp);
		check(32'(rsp), 32'(RESP_SLVERR));
		dev_wr(IO_ADDRESS, 8'hFF);
		dev_rd(IO_ADDRESS, b);
		check(32'(b), 32'h3F);
		tend("reset and map");

		prog_start(8'h05, 8'hA5, MODE_ERASE_WRITE, 8'h00);
		// A reset in mid-programming must let the operation finish.
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		k = n_stall;
		dev_rd(IO_CONTROL, b);
		check(32'(b[1]), 32'h1);
		dev_wr(IO_CONTROL, 8'h31);
		dev_rd(IO_CONTROL, b);
		check(32'(b[5:4]), 32'(MODE_ERASE_WRITE));
		dev_rd(IO_DATA, b);
		check(32'(b), 32'h0);
		check(32'(n_stall - k), 32'h0);
		prog_end(MODE_ERASE_WRITE);
		mem_rd(8'h05, b);
		check(32'(b), 32'hA5);
		tend("atomic");

		for (i = 0; i < 4; i++) begin
			prog_start(ta[i], td[i], tm[i], 8'h00);
			prog_end(tm[i]);
			mem_rd(ta[i], b);
			check(32'(b), 32'(te[i]));
		end
		mem_rd(8'h00, b);
		check(32'(b), 32'h11);
		tend("modes");

		k = n_stall;
		dev_wr(IO_CONTROL, 8'h04);
		dev_rd(IO_CONTROL, b);
		check(32'(b[2]), 32'h0);
		dev_wr(IO_CONTROL, 8'h02);
		cmd(IO_CONTROL, 8'h34, 1'b0);
		cmd(IO_CONTROL, 8'h36, 1'b0);
		wait_host();
		check(32'(n_stall - k), 32'h0);
		dev_rd(IO_CONTROL, b);
		check(32'(b[1]), 32'h0);
		tend("refused starts");

		s_axi_wstrb <= 4'h0;
		axi_write(AXI_IRQ_MASK, 32'h3, rsp);
		s_axi_wstrb <= 4'hF;
		axi_read(AXI_IRQ_MASK, r, rsp);
		check(r, 32'h0);
		axi_write(AXI_IRQ_MASK, 32'h0, rsp);
		axi_write(AXI_CONTROL, 32'h1, rsp);
		dev_wr(IO_CONTROL, 8'h08);
		repeat (3) @(posedge aclk);
		check(32'(ebc_io_if_inst.irq), 32'h1);
		check(32'(host_irq), 32'h0);
		axi_write(AXI_IRQ_MASK, 32'h2, rsp);
		check(32'(rsp), 32'(RESP_OKAY));
		repeat (3) @(posedge aclk);
		check(32'(host_irq), 32'h1);
		axi_read(AXI_IRQ_STAT, r, rsp);
		check(32'(r[EV_READY]), 32'h1);
		check(32'(r[EV_DONE]), 32'h1);
		repeat (3) @(posedge aclk);
		check(32'(host_irq), 32'h0);
		prog_start(8'h07, 8'h42, MODE_ERASE_WRITE, 8'h08);
		check(32'(ebc_io_if_inst.irq), 32'h0);
		prog_end(MODE_ERASE_WRITE);
		check(32'(host_irq), 32'h1);
		axi_write(AXI_CONTROL, 32'h0, rsp);
		repeat (3) @(posedge aclk);
		check(32'(ebc_io_if_inst.irq), 32'h0);
		tend("interrupt");
		final_report();
	end
endmodule : eeprom_byte_access_controller_tb
